// *** otppg_pkg.sv ***
/*
  Constants for the one-time-programmable memory programmer controller.
  Assumes a 200 MHz clock and external level shifters that turn the
  high-voltage enables into the programming and identification voltages.
*/
// Contract
// [R1] Program pulses last 30 to 105 us, only as needed.
// [R2] Read back and compare after every pulse.
// [R3] Repeat pulses on mismatch until match or limit.
// [R4] Step sequentially through every address.
// [R5] Final read-back pass over whole memory.
// [R6] Parallel devices share all but chip select.
// [R7] Low chip select with supply voltage programs.
// [R8] Verify with chip select and output gate low.
// [R9] Sample verify data after data-valid delay.
// [R10] Identification needs high voltage on address bit 9.
// [R11] Bit 1 high: bit 0 picks maker or type byte.
// [R12] Other address bits high during identification.
// [R13] Identifier bytes have odd parity.
// [R14] Bit 1 low returns the continuation code.
// [R15] Data driven only with both enables low.
// [R16] Output gate only gates data to pins.
// [R17] Data valid output-gate delay after gate falls.
// [R18] Chip select high keeps outputs high impedance.
// [R19] Decode chip select, share output gate strobe.
// [R20] Blank bits read one; programming clears bits.
// [R21] Program byte presented on all eight data lines.
// [R22] Address access 70 ns or 90 ns grade.
// [R23] Pulse width 30 to 105 us, 75 typical.
// [R24] Pulse limit configurable; flag failure when exhausted.
package otppg_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_LAST = 16'hffff;
  localparam logic [ADDR_W-1:0] ID_ADDR_BASE = 16'hfdfc;
  localparam int ID_BIT_A0 = 0;
  localparam int ID_BIT_A1 = 1;
  localparam logic [DATA_W-1:0] BLANK_BYTE = 8'hff;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int PULSE_US = 75;
  localparam int PULSE_MIN_US = 30;
  localparam int PULSE_MAX_US = 105;
  localparam int SETUP_US = 2;
  localparam int VERIFY_DV_NS = 150;
  localparam int ACCESS_NS = 90;
  localparam int PULSE_CYC = PULSE_US * 1000000 / CLK_PERIOD_PS;
  localparam int SETUP_CYC = (SETUP_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DV_CYC = (VERIFY_DV_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ACC_CYC = (ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SYNC_SLACK = 3;
  localparam int TMR_W = 16;
  localparam int PCNT_W = 8;
  localparam logic [PCNT_W-1:0] PULSE_LIMIT_DEF = 8'h19;
  localparam logic [1:0] CMD_READ = 2'h0;
  localparam logic [1:0] CMD_PROG = 2'h1;
  localparam logic [1:0] CMD_IDENT = 2'h2;
  localparam logic [1:0] CMD_CHECK = 2'h3;
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_SETUP  = 4'h1,
    ST_PULSE  = 4'h3,
    ST_RECOV  = 4'h2,
    ST_VERIFY = 4'h6,
    ST_NEXT   = 4'h7,
    ST_FINAL  = 4'h5,
    ST_READ   = 4'h4,
    ST_DONE   = 4'hc
  } otppg_state_t;
endpackage

// *** otppg_timer.sv ***
/*
  Down-counting delay timer for the programmer controller.
  Assumes a single clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module otppg_timer
(
  input  wire logic                        clock,
  input  wire logic                        srst,
  input  wire logic                        load,
  input  wire logic [otppg_pkg::TMR_W-1:0] count,
  output logic                             expired
);
  logic [otppg_pkg::TMR_W-1:0] cnt_r;

  always_ff @(posedge clock)
  begin
    if (srst)
      cnt_r <= 16'h0000;
    else if (load)
      cnt_r <= count;
    else if (cnt_r != 16'h0000)
      cnt_r <= cnt_r - 16'h0001;
  end

  // Expired looks only at the count, so a caller may reload on expiry without a loop.
  assign expired = (cnt_r == 16'h0000);
endmodule

// *** otppg_ctrl.sv ***
/*
  Programmer controller: runs the pulse-and-verify algorithm, the final
  read-back pass, plain reads and identification reads on one device.
  Assumes external drivers turn vpp_en into the programming voltage on the
  output-gate pin and id_hv_en into the identification voltage on address
  bit 9. Several devices may share every output except chip_sel_n.
*/
`timescale 1ns/10ps
module otppg_ctrl
(
  input  wire logic                         clock,
  input  wire logic                         srst,
  input  wire logic                         start,
  input  wire logic [1:0]                   cmd,
  input  wire logic [otppg_pkg::ADDR_W-1:0] user_addr,
  input  wire logic [otppg_pkg::PCNT_W-1:0] pulse_limit,
  input  wire logic [otppg_pkg::DATA_W-1:0] wr_data,
  output logic                              wr_req,
  output logic [otppg_pkg::ADDR_W-1:0]      wr_addr,
  output logic [otppg_pkg::DATA_W-1:0]      rd_data,
  output logic                              rd_valid,
  output logic                              busy,
  output logic                              done,
  output logic                              fail,
  output logic                              parity_err,
  output logic [otppg_pkg::ADDR_W-1:0]      address_lines,
  input  wire logic [otppg_pkg::DATA_W-1:0] data_lines_in,
  output logic [otppg_pkg::DATA_W-1:0]      data_lines_out,
  output logic                              data_lines_oe,
  output logic                              chip_sel_n,
  output logic                              out_gate_n,
  output logic                              vpp_en,
  output logic                              id_hv_en
);
  otppg_pkg::otppg_state_t state_r;
  logic [1:0]                   cmd_r;
  logic [otppg_pkg::ADDR_W-1:0] addr_r;
  logic [otppg_pkg::DATA_W-1:0] target_r;
  logic [otppg_pkg::PCNT_W-1:0] pcnt_r;
  logic [otppg_pkg::PCNT_W-1:0] limit_r;
  logic [otppg_pkg::DATA_W-1:0] din_s1_r;
  logic [otppg_pkg::DATA_W-1:0] din_s2_r;
  logic                         tmr_load;
  logic [otppg_pkg::TMR_W-1:0]  tmr_count;
  logic                         tmr_expired;
  logic                         final_r;

  function automatic logic odd_parity(input logic [otppg_pkg::DATA_W-1:0] b);
    odd_parity = ^b;
  endfunction

  // Address used in identification mode: bits 2 to 15 held high except bit 9.
  function automatic logic [otppg_pkg::ADDR_W-1:0] id_addr(input logic [1:0] sel);
    logic [otppg_pkg::ADDR_W-1:0] a;
    a = otppg_pkg::ID_ADDR_BASE;
    a[otppg_pkg::ID_BIT_A0] = sel[0];
    a[otppg_pkg::ID_BIT_A1] = sel[1];
    id_addr = a;
  endfunction

  otppg_timer u_timer
  (
    .clock   (clock),
    .srst    (srst),
    .load    (tmr_load),
    .count   (tmr_count),
    .expired (tmr_expired)
  );

  // Data pins come from another domain, so two flops precede any use.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      din_s1_r <= 8'h00;
      din_s2_r <= 8'h00;
    end
    else
    begin
      din_s1_r <= data_lines_in;
      din_s2_r <= din_s1_r;
    end
  end

  wire match = (din_s2_r == target_r);

  // Timer reloads as each timed state is entered, except SETUP after FINAL; sync slack covers the two flops.
  always_comb
  begin
    tmr_load  = 1'b0;
    tmr_count = 16'h0000;
    unique case (state_r)
      otppg_pkg::ST_IDLE:
      begin
        tmr_load  = start;
        tmr_count = 16'(otppg_pkg::SETUP_CYC);
      end
      otppg_pkg::ST_SETUP:
      begin
        tmr_load  = tmr_expired;
        tmr_count = (cmd_r == otppg_pkg::CMD_PROG && !final_r)
                    ? 16'(otppg_pkg::PULSE_CYC)
                    : 16'(otppg_pkg::ACC_CYC + otppg_pkg::SYNC_SLACK);
      end
      otppg_pkg::ST_PULSE:
      begin
        tmr_load  = tmr_expired;
        tmr_count = 16'(otppg_pkg::SETUP_CYC);
      end
      otppg_pkg::ST_RECOV:
      begin
        tmr_load  = tmr_expired;
        tmr_count = 16'(otppg_pkg::DV_CYC + otppg_pkg::SYNC_SLACK); // see [R9]
      end
      // A retry needs the full data and supply setup again before its pulse.
      otppg_pkg::ST_VERIFY:
      begin
        tmr_load  = tmr_expired;
        tmr_count = 16'(otppg_pkg::SETUP_CYC); // see [R3]
      end
      otppg_pkg::ST_NEXT:
      begin
        tmr_load  = 1'b1;
        tmr_count = 16'(otppg_pkg::SETUP_CYC);
      end
      default:
      begin
        tmr_load  = 1'b0;
        tmr_count = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state_r <= otppg_pkg::ST_IDLE;
      final_r <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        otppg_pkg::ST_IDLE:
          if (start)
          begin
            state_r <= otppg_pkg::ST_SETUP;
            final_r <= (cmd == otppg_pkg::CMD_CHECK);
          end
        otppg_pkg::ST_SETUP:
          if (tmr_expired)
            state_r <= (cmd_r == otppg_pkg::CMD_PROG && !final_r)
                       ? otppg_pkg::ST_PULSE : otppg_pkg::ST_READ;
        otppg_pkg::ST_PULSE:
          if (tmr_expired)
            state_r <= otppg_pkg::ST_RECOV; // see [R1] [R23]
        otppg_pkg::ST_RECOV:
          if (tmr_expired)
            state_r <= otppg_pkg::ST_VERIFY; // see [R2]
        otppg_pkg::ST_VERIFY:
          if (tmr_expired)
          begin
            if (match)
              state_r <= otppg_pkg::ST_NEXT;
            else if (pcnt_r >= limit_r)
              state_r <= otppg_pkg::ST_DONE; // see [R24]
            else
              state_r <= otppg_pkg::ST_SETUP; // see [R3]
          end
        otppg_pkg::ST_NEXT:
          if (addr_r == otppg_pkg::ADDR_LAST)
          begin
            state_r <= otppg_pkg::ST_SETUP;
            final_r <= 1'b1; // see [R5]
          end
          else
            state_r <= otppg_pkg::ST_SETUP; // see [R4]
        otppg_pkg::ST_READ:
          if (tmr_expired)
          begin
            if (final_r && (!match || addr_r == otppg_pkg::ADDR_LAST))
              state_r <= otppg_pkg::ST_DONE;
            else if (final_r)
              state_r <= otppg_pkg::ST_FINAL;
            else
              state_r <= otppg_pkg::ST_DONE;
          end
        otppg_pkg::ST_FINAL:
          state_r <= otppg_pkg::ST_SETUP;
        otppg_pkg::ST_DONE:
          state_r <= otppg_pkg::ST_IDLE;
        default:
          state_r <= otppg_pkg::ST_IDLE;
      endcase
    end
  end

  // Address, pulse count and target byte bookkeeping.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      cmd_r    <= otppg_pkg::CMD_READ;
      addr_r   <= 16'h0000;
      pcnt_r   <= 8'h00;
      limit_r  <= otppg_pkg::PULSE_LIMIT_DEF;
      target_r <= otppg_pkg::BLANK_BYTE;
    end
    else
    begin
      if (state_r == otppg_pkg::ST_IDLE && start)
      begin
        cmd_r   <= cmd;
        addr_r  <= (cmd == otppg_pkg::CMD_IDENT) ? id_addr(user_addr[1:0])
                 : (cmd == otppg_pkg::CMD_READ) ? user_addr : 16'h0000;
        pcnt_r  <= 8'h00;
        limit_r <= (pulse_limit == 8'h00) ? otppg_pkg::PULSE_LIMIT_DEF : pulse_limit;
      end
      if (state_r == otppg_pkg::ST_PULSE && tmr_expired)
        pcnt_r <= pcnt_r + 8'h01;
      if (state_r == otppg_pkg::ST_NEXT || state_r == otppg_pkg::ST_FINAL)
      begin
        addr_r <= (state_r == otppg_pkg::ST_NEXT && addr_r == otppg_pkg::ADDR_LAST)
                  ? 16'h0000 : addr_r + 16'h0001;
        pcnt_r <= 8'h00;
      end
      if (wr_req)
        target_r <= wr_data;
    end
  end

  // Byte requests go out one cycle ahead of each address's first use.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      wr_req  <= 1'b0;
      wr_addr <= 16'h0000;
    end
    else
    begin
      wr_req  <= (state_r == otppg_pkg::ST_IDLE && start && cmd != otppg_pkg::CMD_READ
                  && cmd != otppg_pkg::CMD_IDENT)
              || state_r == otppg_pkg::ST_NEXT || state_r == otppg_pkg::ST_FINAL;
      wr_addr <= (state_r == otppg_pkg::ST_IDLE) ? 16'h0000
               : (addr_r == otppg_pkg::ADDR_LAST) ? 16'h0000 : addr_r + 16'h0001;
    end
  end

  // Pin drive; outputs return to safe idle levels with chip select high in IDLE and DONE.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      address_lines  <= 16'h0000;
      data_lines_out <= 8'h00;
      data_lines_oe  <= 1'b0;
      chip_sel_n     <= 1'b1;
      out_gate_n     <= 1'b1;
      vpp_en         <= 1'b0;
      id_hv_en       <= 1'b0;
    end
    else
    begin
      address_lines  <= addr_r;
      data_lines_out <= target_r; // see [R21]
      data_lines_oe  <= cmd_r == otppg_pkg::CMD_PROG && !final_r &&
                        (state_r == otppg_pkg::ST_SETUP || state_r == otppg_pkg::ST_PULSE);
      vpp_en         <= cmd_r == otppg_pkg::CMD_PROG && !final_r &&
                        (state_r == otppg_pkg::ST_SETUP || state_r == otppg_pkg::ST_PULSE);
      chip_sel_n     <= !(state_r == otppg_pkg::ST_PULSE || state_r == otppg_pkg::ST_VERIFY
                          || state_r == otppg_pkg::ST_READ); // see [R6] [R7] [R19]
      out_gate_n     <= !(state_r == otppg_pkg::ST_VERIFY
                          || state_r == otppg_pkg::ST_READ); // see [R8] [R15]
      id_hv_en       <= cmd_r == otppg_pkg::CMD_IDENT && state_r != otppg_pkg::ST_IDLE
                        && state_r != otppg_pkg::ST_DONE; // see [R10] [R12]
    end
  end

  // Result reporting.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      rd_data    <= 8'h00;
      rd_valid   <= 1'b0;
      busy       <= 1'b0;
      done       <= 1'b0;
      fail       <= 1'b0;
      parity_err <= 1'b0;
    end
    else
    begin
      rd_valid <= state_r == otppg_pkg::ST_READ && tmr_expired && !final_r; // see [R17] [R22]
      if (state_r == otppg_pkg::ST_READ && tmr_expired)
      begin
        rd_data    <= din_s2_r;
        parity_err <= cmd_r == otppg_pkg::CMD_IDENT && addr_r[otppg_pkg::ID_BIT_A1]
                      && !odd_parity(din_s2_r); // see [R11] [R13]
      end
      busy <= state_r != otppg_pkg::ST_IDLE && state_r != otppg_pkg::ST_DONE;
      done <= state_r == otppg_pkg::ST_DONE;
      if (state_r == otppg_pkg::ST_IDLE && start)
        fail <= 1'b0;
      else if (state_r == otppg_pkg::ST_VERIFY && tmr_expired && !match
               && pcnt_r >= limit_r)
        fail <= 1'b1;
      else if (state_r == otppg_pkg::ST_READ && tmr_expired && final_r && !match)
        fail <= 1'b1;
    end
  end
endmodule

// *** otppg_props.sv ***
/*
  Port checker for the programmer controller.
  Assumes it is bound to otppg_ctrl and sees only that module's ports.
*/
`timescale 1ns/10ps
module otppg_props
(
  input wire logic        clock,
  input wire logic        srst,
  input wire logic [15:0] address_lines,
  input wire logic        data_lines_oe,
  input wire logic        chip_sel_n,
  input wire logic        out_gate_n,
  input wire logic        vpp_en,
  input wire logic        id_hv_en,
  input wire logic        wr_req,
  input wire logic        done
);
  logic [15:0] low_r;

  // Saturates so that a stuck select cannot wrap back into the legal window.
  always_ff @(posedge clock)
  begin
    if (srst || chip_sel_n)
      low_r <= 16'h0000;
    else if (low_r != 16'hffff)
      low_r <= low_r + 16'h0001;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  // Select and supply drop on the same edge, so the supply is looked at one cycle back.
  pulse_width_a: assert property ($rose(chip_sel_n) && $past(vpp_en) |->
    low_r >= 16'h1770 && low_r <= 16'h5208) else $error("program pulse width out of range");
  no_contention_a: assert property (!out_gate_n |-> !data_lines_oe)
    else $error("controller drives data while device output is gated on");
  prog_data_a: assert property ($fell(chip_sel_n) && vpp_en |-> data_lines_oe)
    else $error("program pulse without data driven");
  verify_after_a: assert property ($rose(chip_sel_n) && $past(vpp_en) |->
    ##[1:1000] (!chip_sel_n && !out_gate_n && !vpp_en)) else $error("no verify after pulse");
  id_address_a: assert property (id_hv_en && !chip_sel_n |->
    (address_lines | 16'h0203) == 16'hffff) else $error("identification address not high");
  id_enables_a: assert property (id_hv_en && !out_gate_n |->
    !chip_sel_n && !vpp_en) else $error("identification without both enables low");
  addr_hold_a: assert property (!chip_sel_n && $past(!chip_sel_n) |->
    $stable(address_lines)) else $error("address moved while selected");
  read_hold_a: assert property ($rose(chip_sel_n) && !$past(vpp_en) |->
    low_r >= 16'h000e) else $error("data taken before the valid delay");
  addr_step_a: assert property (wr_req |=> !done[*2])
    else $error("done right after a data request");
endmodule

bind otppg_ctrl otppg_props otppg_props_inst (.clock, .srst, .address_lines, .data_lines_oe,
  .chip_sel_n, .out_gate_n, .vpp_en, .id_hv_en, .wr_req, .done);

// *** otppg_device.sv ***
/*
  Behavioural model of the one-time-programmable memory device.
  Assumes the controller drives every pin from the same clock.
*/
`timescale 1ns/10ps
module otppg_device
#(
  parameter int         ACC_CYC   = 14,
  parameter logic [7:0] MFR_CODE  = 8'h2a,
  parameter logic [7:0] DEV_CODE  = 8'h45,
  parameter logic [7:0] CONT_CODE = 8'h6e
)
(
  input  wire logic        clock,
  input  wire logic [15:0] address_lines,
  input  wire logic [7:0]  data_lines_out,
  input  wire logic        data_lines_oe,
  input  wire logic        chip_sel_n,
  input  wire logic        out_gate_n,
  input  wire logic        vpp_en,
  input  wire logic        id_hv_en,
  input  wire logic        bad_id,
  input  wire logic        stuck,
  output logic [7:0]       data_lines_in
);
  // The three codes are arbitrary values with odd parity.
  logic [7:0]  mem [logic [15:0]];
  logic [15:0] addr_r;
  int          act_r;

  initial data_lines_in = 8'h00;

  always @(posedge clock)
  begin
    logic [7:0] v;
    v = mem.exists(address_lines) ? mem[address_lines] : 8'hff;
    if (vpp_en && !chip_sel_n && data_lines_oe && !stuck)
      mem[address_lines] = v & data_lines_out;
    if (id_hv_en)
      v = (address_lines[1] ? (address_lines[0] ? DEV_CODE : MFR_CODE) : CONT_CODE)
        ^ {7'h00, bad_id};
    act_r <= (chip_sel_n || address_lines != addr_r) ? 0 : act_r + 1;
    addr_r <= address_lines;
    // Released lines flip every cycle so a stale byte can never pass for data.
    if (!chip_sel_n && !out_gate_n && !vpp_en && act_r >= ACC_CYC)
      data_lines_in <= v;
    else
      data_lines_in <= ~data_lines_in;
  end
endmodule

// *** otp_eprom_mode_control_bench.sv ***
/*
  Self-checking bench for the programmer controller with a device model.
  Assumes otppg_pkg, otppg_ctrl, otppg_device and otppg_props are compiled.
*/
`timescale 1ns/10ps
module otp_eprom_mode_control_bench;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic        start = 1'b0;
  logic [1:0]  cmd = 2'h0;
  logic [15:0] user_addr = 16'h0000;
  logic [7:0]  pulse_limit = 8'h00;
  logic [7:0]  wr_data = 8'h00;
  logic        bad_id = 1'b0;
  logic        stuck = 1'b0;
  logic        wr_req, rd_valid, busy, done, fail, parity_err;
  logic        data_lines_oe, chip_sel_n, out_gate_n, vpp_en, id_hv_en;
  logic [15:0] wr_addr, address_lines;
  logic [7:0]  rd_data, data_lines_in, data_lines_out;
  int          num_errors = 0;
  int          checks = 0;

  always #2.5 clock = ~clock;
  always @(posedge clock) wr_data <= 8'ha5 ^ wr_addr[7:0];

  otppg_ctrl otppg_ctrl_inst (.clock, .srst, .start, .cmd, .user_addr, .pulse_limit, .wr_data,
    .wr_req, .wr_addr, .rd_data, .rd_valid, .busy, .done, .fail, .parity_err, .address_lines,
    .data_lines_in, .data_lines_out, .data_lines_oe, .chip_sel_n, .out_gate_n, .vpp_en,
    .id_hv_en);
  otppg_device otppg_device_inst (.clock, .address_lines, .data_lines_out, .data_lines_oe,
    .chip_sel_n, .out_gate_n, .vpp_en, .id_hv_en, .bad_id, .stuck, .data_lines_in);

  task automatic wrap_up();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Waits on falling edges so registered outputs have settled.
  task automatic wait_for(input int which, input int limit);
    int n;
    for (n = 0; n < limit; n++)
    begin
      @(negedge clock);
      if ((which == 0 && rd_valid === 1'b1) || (which == 1 && done === 1'b1) ||
          (which == 2 && chip_sel_n === 1'b0 && vpp_en === 1'b1) ||
          (which == 3 && chip_sel_n === 1'b1))
        return;
    end
    cmp(1'b0, 1'b1, "wait timed out");
    wrap_up();
  endtask

  task automatic launch(input logic [1:0] c, input logic [15:0] a, input logic [7:0] lim);
    @(posedge clock);
    start <= 1'b1;
    cmd <= c;
    user_addr <= a;
    pulse_limit <= lim;
    @(posedge clock);
    start <= 1'b0;
  endtask

  task automatic read_one(input logic [1:0] c, input logic [15:0] a, input logic [7:0] exp);
    launch(c, a, 8'h00);
    wait_for(0, 3000);
    cmp(rd_data, exp, "read data");
    cmp(busy, 1'b1, "busy during read");
    wait_for(1, 10);
    cmp(parity_err, 1'b0, "parity flag");
    cmp(busy, 1'b0, "busy after done");
  endtask

  task automatic scen_idle();
    @(negedge clock);
    cmp({chip_sel_n, out_gate_n, data_lines_oe, vpp_en, id_hv_en}, 5'h18, "reset pins");
  endtask

  task automatic scen_ident();
    read_one(otppg_pkg::CMD_IDENT, 16'h0002, 8'h2a);
    read_one(otppg_pkg::CMD_IDENT, 16'h0003, 8'h45);
    read_one(otppg_pkg::CMD_IDENT, 16'h0000, 8'h6e);
    read_one(otppg_pkg::CMD_IDENT, 16'h0001, 8'h6e);
    bad_id <= 1'b1;
    launch(otppg_pkg::CMD_IDENT, 16'h0003, 8'h00);
    wait_for(1, 3000);
    cmp(parity_err, 1'b1, "bad parity seen");
    bad_id <= 1'b0;
  endtask

  task automatic scen_program();
    int n;
    launch(otppg_pkg::CMD_PROG, 16'h0000, 8'h02);
    wait_for(2, 3000);
    cmp(address_lines, 16'h0000, "first address");
    cmp(data_lines_out, 8'ha5, "program byte");
    for (n = 0; n < 30000 && chip_sel_n === 1'b0; n++)
      @(negedge clock);
    cmp((n >= 6000 && n <= 21000), 1'b1, "pulse width");
    wait_for(2, 3000);
    cmp(address_lines, 16'h0001, "next address");
    cmp(data_lines_out, 8'ha4, "second byte");
    cmp(wr_addr, 16'h0002, "byte request address");
    @(posedge clock);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    scen_idle();
    read_one(otppg_pkg::CMD_READ, 16'h0000, 8'ha5);
  endtask

  // Locations 0 and 1 already hold their bytes, so the failure lands on location 2.
  task automatic scen_stuck();
    stuck <= 1'b1;
    launch(otppg_pkg::CMD_PROG, 16'h0010, 8'h01);
    wait_for(1, 50000);
    cmp(fail, 1'b1, "pulse limit failure");
    cmp(address_lines, 16'h0002, "failing location");
    stuck <= 1'b0;
  endtask

  task automatic scen_check();
    launch(otppg_pkg::CMD_CHECK, 16'h0000, 8'h00);
    wait_for(1, 3000);
    cmp(fail, 1'b1, "final check mismatch");
    cmp(address_lines, 16'h0002, "final check stop");
  endtask

  initial
  begin
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    scen_idle();
    read_one(otppg_pkg::CMD_READ, 16'h1234, 8'hff);
    scen_ident();
    scen_program();
    scen_stuck();
    scen_check();
    wrap_up();
  end
endmodule
